// ==== tb_tcp_timer_capture_pwm.sv ====
// Self-checking testbench of the timer capture and PWM block
`timescale 1ns/1ps
module tb_tcp_timer_capture_pwm
  import tcp_pkg::*;
;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} tcp_note_s;

  // ==========================================================
  // Stimulus and observed signals
  logic              clk_sys       = 1'b0;
  logic              rst_n         = 1'b0;
  logic [ADDR_W-1:0] avsAddress    = '0;
  logic              avsRead       = 1'b0;
  logic              avsWrite      = 1'b0;
  logic [31:0]       avsWritedata  = '0;
  logic [3:0]        avsByteenable = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              pinFirst;
  logic              pinSecond;
  logic              outFirst;
  logic              irq;
  tcp_note_s         expQ[$];
  tcp_note_s         note;
  int                nMismatch     = 0;
  int                checkCount    = 0;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  tcp_timer_capture_pwm u_tcp_timer_capture_pwm (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .avs_address        (avsAddress),
    .avs_read           (avsRead),
    .avs_write          (avsWrite),
    .avs_writedata      (avsWritedata),
    .avs_byteenable     (avsByteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .capturePinFirst    (pinFirst),
    .capturePinSecond   (pinSecond),
    .compareOutPinFirst (outFirst),
    .irq                (irq)
  );

  tcp_pin_source u_tcp_pin_source (
    .clk_sys   (clk_sys),
    .pinFirst  (pinFirst),
    .pinSecond (pinSecond)
  );

  // ==========================================================
  // Comparison and closing report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    $display("mismatches %0d checks %0d", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finishTest

  // ==========================================================
  // Bus master: hold the request until waitrequest is sampled low
  task automatic busAccess(input logic wr, input logic [ADDR_W-1:0] addr,
                           input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    avsAddress    <= addr;
    avsWrite      <= wr;
    avsRead       <= ~wr;
    avsWritedata  <= wd;
    avsByteenable <= be;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0)
    begin
      nMismatch++;
      finishTest();
    end
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk_sys);
  endtask : busAccess

  task automatic regWrite(input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                          input logic [3:0] be);
    logic [31:0] d;
    busAccess(1'b1, addr, wd, be, d);
  endtask : regWrite

  // Note the expected read value, then issue the read
  task automatic regRead(input string name, input logic [ADDR_W-1:0] addr,
                         input logic [31:0] exp, input logic [31:0] mask, output logic [31:0] rd);
    expQ.push_back('{name, exp, mask});
    busAccess(1'b0, addr, 32'h0, 4'hf, rd);
  endtask : regRead

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : doReset

  // Change both pins, then give the synchroniser time to report
  task automatic pins(input logic v1, input logic v2, input int gap);
    u_tcp_pin_source.drive(v1, v2, gap);
    repeat (6) @(posedge clk_sys);
  endtask : pins

  // ==========================================================
  // Monitor: each read answer is matched against the oldest note
  always @(posedge clk_sys)
  begin
    if (avsRead === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (expQ.size() == 0)
        check("unexpected read", 32'h1, 32'h0);
      else
      begin
        note = expQ.pop_front();
        check(note.name, avs_readdata & note.mask, note.exp & note.mask);
      end
    end
  end

  // Watchdog cuts a hang short
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    nMismatch++;
    finishTest();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0]       d;
    logic [31:0]       rnd;
    logic [CTRL_W-1:0] ctrl;
    logic              prev;
    int                hi;
    int                rises;
    int                hiPer;
    int                per;
    static int         c1[4]  = '{5, 5, 10, 10};
    static int         c2[4]  = '{23, 23, 29, 29};
    static logic       l1[4]  = '{1'b1, 1'b0, 1'b1, 1'b0};
    static logic       l2[4]  = '{1'b0, 1'b1, 1'b1, 1'b0};
    static logic       spm[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    void'($urandom(3));
    @(posedge clk_sys);
    doReset();
    // Reset values, read-only and unmapped places, full-range compare values
    regRead("ctrl rst", OFS_CTRL, 32'(CTRL_RST), '1, d);
    regRead("cmp1 rst", OFS_CMP1, 32'(CMP1_RST), '1, d);
    regRead("cmp2 rst", OFS_CMP2, 32'(CMP2_RST), '1, d);
    regRead("mask rst", OFS_MASK, 32'(MASK_RST), '1, d);
    regRead("stat rst", OFS_STATUS, 32'(STAT_RST), 32'h3, d);
    regWrite(OFS_CAP1, 32'hffff, 4'hf);
    regRead("cap1 ro", OFS_CAP1, 32'h0, '1, d);
    regRead("unmapped", 5'h02, 32'h0, '1, d);
    rnd = $urandom();
    regWrite(OFS_CMP1, rnd, 4'hf);
    regRead("cmp1 rw", OFS_CMP1, {16'h0, rnd[15:0]}, '1, d);
    regWrite(OFS_CMP2, rnd, 4'h1);
    regRead("cmp2 lane", OFS_CMP2, {16'h0, 8'hff, rnd[7:0]}, '1, d);
    // Two back-to-back reads of the counter lie three clocks apart
    regRead("count", OFS_COUNT, 32'h0, 32'h0, d);
    regRead("count run", OFS_COUNT, d + 32'd3, 32'hffff, d);
    // Rising edges on both channels, 17 clocks apart
    regWrite(OFS_CTRL, 32'h0c, 4'hf);
    regWrite(OFS_MASK, 32'h3, 4'hf);
    pins(1'b1, 1'b1, 17);
    regRead("cap flags", OFS_STATUS, 32'h3, 32'h3, d);
    check("irq set", {31'h0, irq}, 32'h1);
    regRead("cap2", OFS_CAP2, 32'h0, 32'h0, d);
    regRead("cap gap", OFS_CAP1, d + 32'd17, 32'hffff, d);
    regWrite(OFS_STATUS, 32'h3, 4'h1);
    repeat (2) @(posedge clk_sys);
    check("irq clear", {31'h0, irq}, 32'h0);
    // Edge select in both codes
    pins(1'b0, 1'b0, 0);
    regRead("no fall", OFS_STATUS, 32'h0, 32'h3, d);
    regWrite(OFS_CTRL, 32'h00, 4'hf);
    pins(1'b1, 1'b1, 0);
    regRead("no rise", OFS_STATUS, 32'h0, 32'h3, d);
    pins(1'b0, 1'b0, 0);
    regRead("fall", OFS_STATUS, 32'h3, 32'h3, d);
    // Single pulse mode leaves only the second channel
    doReset();
    regWrite(OFS_CTRL, 32'h0e, 4'hf);
    pins(1'b1, 1'b1, 0);
    regRead("opm cap", OFS_STATUS, 32'h2, 32'h3, d);
    pins(1'b0, 1'b0, 0);
    // PWM level table, one entry also in single pulse mode
    for (int i = 0; i < 4; i++)
    begin
      doReset();
      regWrite(OFS_CMP2, 32'(c2[i]), 4'hf);
      regWrite(OFS_CMP1, 32'(c1[i]), 4'hf);
      ctrl = '0;
      ctrl[CTRL_PWM] = 1'b1;
      ctrl[CTRL_SPM] = spm[i];
      ctrl[CTRL_EDGE2] = 1'b1;
      ctrl[CTRL_LVL1] = l1[i];
      ctrl[CTRL_LVL2] = l2[i];
      regWrite(OFS_CTRL, 32'(ctrl), 4'hf);
      // Drop compare flags raised by matches before PWM started
      regWrite(OFS_STATUS, 32'hf, 4'h1);
      regWrite(OFS_MASK, 32'h1, 4'hf);
      pins(1'b1, 1'b1, 0);
      repeat (60) @(posedge clk_sys);
      per = c2[i] + 1;
      hiPer = l1[i] ? (l2[i] ? per : c2[i] - c1[i]) : (l2[i] ? c1[i] + 1 : 0);
      hi = 0;
      rises = 0;
      prev = outFirst;
      repeat (120)
      begin
        @(posedge clk_sys);
        if (outFirst === 1'b1)
          hi++;
        if (outFirst === 1'b1 && prev === 1'b0)
          rises++;
        prev = outFirst;
      end
      check("pwm high", 32'(hi), 32'(120 * hiPer / per));
      check("pwm rises", 32'(rises), (l1[i] != l2[i]) ? 32'(120 / per) : 32'h0);
      regRead("pwm flags", OFS_STATUS, 32'h3, 32'hf, d);
      check("pwm irq", {31'h0, irq}, 32'h1);
      regWrite(OFS_CTRL, 32'h00, 4'hf);
      repeat (3) @(posedge clk_sys);
      check("pwm off", {31'h0, outFirst}, 32'h0);
      pins(1'b0, 1'b0, 0);
    end
    finishTest();
  end
endmodule : tb_tcp_timer_capture_pwm

// ==== tcp_capture_chan.sv ====
// One input capture channel with pin synchroniser and edge detect
`timescale 1ns/1ps
module tcp_capture_chan
  import tcp_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  logic             clk_sys,
  input  logic             rst_n,
  input  logic             capturePin,
  input  logic             edgeRising,
  input  logic             enable,
  tcp_timebase_if.snk      tb,
  output logic             capEvent,
  output logic [CNT_W-1:0] capValue
);

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic             prev;
    logic [1:0]       warm;
    logic             ev;
    logic [CNT_W-1:0] value;
  } tcp_cap_s;

  tcp_cap_s r;
  tcp_cap_s n;
  logic     hit;

  // ==========================================================
  // Next state: sync, edge detect, latch
  always_comb
  begin
    n = r;
    n.sync1 = capturePin;
    n.sync2 = r.sync1;
    n.prev  = r.sync2;
    if (r.warm != 2'h3)
    begin
      n.warm = r.warm + 2'h1;
    end
    hit = (edgeRising == EDGE_RISE) ? (r.sync2 & ~r.prev)
                                    : (~r.sync2 & r.prev);
    n.ev = enable & hit & (r.warm == 2'h3);
    if (n.ev)
    begin
      n.value = tb.count;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign capEvent = r.ev;
  assign capValue = r.value;

endmodule : tcp_capture_chan

// ==== tcp_pin_source.sv ====
// Behavioural model of the event sources wired to the two capture pins
`timescale 1ns/1ps
module tcp_pin_source
(
  input  logic clk_sys,
  output logic pinFirst,
  output logic pinSecond
);
  // ==========================================================
  // Both pins idle low from time zero
  initial
  begin
    pinFirst  = 1'b0;
    pinSecond = 1'b0;
  end

  // Second pin moves first, first pin follows after a gap of clocks
  task automatic drive(input logic v1, input logic v2, input int gap);
    pinSecond <= v2;
    repeat (gap) @(posedge clk_sys);
    pinFirst <= v1;
  endtask : drive
endmodule : tcp_pin_source

// ==== tcp_pkg.sv ====
// Constants, types and helpers for the timer capture and PWM block
package tcp_pkg;

  // ==========================================================
  // Sizes
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 5;
  localparam int CTRL_W = 6;
  localparam int STAT_W = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CMP1   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP2   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CAP1   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAP2   = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h1c;

  // ==========================================================
  // Control fields
  localparam int CTRL_PWM   = 0;
  localparam int CTRL_SPM   = 1;
  localparam int CTRL_EDGE1 = 2;
  localparam int CTRL_EDGE2 = 3;
  localparam int CTRL_LVL1  = 4;
  localparam int CTRL_LVL2  = 5;

  // Status and mask fields
  localparam int STAT_CAP1 = 0;
  localparam int STAT_CAP2 = 1;
  localparam int STAT_CMP1 = 2;
  localparam int STAT_CMP2 = 3;

  // ==========================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [CNT_W-1:0]  CMP1_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CMP2_RST = 16'hffff;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 4'h0;

  // Edge select codes
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  // ==========================================================
  // Bus handshake states
  typedef enum logic [1:0] {
    TCP_BUS_IDLE = 2'b01,
    TCP_BUS_ACK  = 2'b10
  } tcp_bus_e;

  // Merge write data into a word under byte enables
  function automatic logic [31:0] tcp_be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : tcp_be_merge

endpackage : tcp_pkg

// ==== tcp_pwm_unit.sv ====
// Counter free-running outside PWM and restarting on second match in PWM, compare matches and PWM output
`timescale 1ns/1ps
module tcp_pwm_unit
  import tcp_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  logic             clk_sys,
  input  logic             rst_n,
  input  logic             pwmOn,
  input  logic             levelFirst,
  input  logic             levelSecond,
  input  logic [CNT_W-1:0] compareValueFirst,
  input  logic [CNT_W-1:0] compareValueSecond,
  tcp_timebase_if.src      tb,
  output logic             compareOutPinFirst
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             m1;
    logic             m2;
    logic             out;
  } tcp_pwm_s;

  tcp_pwm_s r;
  tcp_pwm_s n;

  // ==========================================================
  // Next state: count, match, drive output
  always_comb
  begin
    n = r;
    n.m1 = (r.count == compareValueFirst);
    n.m2 = (r.count == compareValueSecond);
    n.count = r.count + 1'b1;
    if (pwmOn && n.m2)
    begin
      n.count = '0;
    end
    if (!pwmOn)
    begin
      n.out = 1'b0;  // Idle low outside PWM
    end
    else if (n.m2)
    begin
      n.out = levelSecond;
    end
    else if (n.m1)
    begin
      n.out = levelFirst;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign tb.count           = r.count;
  assign tb.matchFirst      = r.m1;
  assign tb.matchSecond     = r.m2;
  assign compareOutPinFirst = r.out;

endmodule : tcp_pwm_unit

// ==== tcp_timebase_if.sv ====
// Counter and compare-match bundle shared by the timer sub-blocks
`timescale 1ns/1ps
interface tcp_timebase_if #(parameter int CNT_W = 16);
  logic [CNT_W-1:0] count;
  logic             matchFirst;
  logic             matchSecond;

  // ==========================================================
  // Producer and consumer views
  modport src (output count, output matchFirst, output matchSecond);
  modport snk (input count, input matchFirst, input matchSecond);
endinterface : tcp_timebase_if

// ==== tcp_timer_capture_pwm.sv ====
// Timer capture and PWM block with Avalon-MM register slave
`timescale 1ns/1ps
module tcp_timer_capture_pwm
  import tcp_pkg::*;
#(
  parameter int CNT_W = tcp_pkg::CNT_W
)
(
  input  logic              clk_sys,
  input  logic              rst_n,
  input  logic [ADDR_W-1:0] avs_address,
  input  logic              avs_read,
  input  logic              avs_write,
  input  logic [31:0]       avs_writedata,
  input  logic [3:0]        avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  logic              capturePinFirst,
  input  logic              capturePinSecond,
  output logic              compareOutPinFirst,
  output logic              irq
);

  // ==========================================================
  // Parameter check
  if (CNT_W < 2 || CNT_W > 32)
  begin : gBadWidth
    $error("CNT_W must lie between 2 and 32");
  end

  // ==========================================================
  // Block state
  typedef struct packed {
    tcp_bus_e          bus;
    logic              waitReq;
    logic [31:0]       rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  cmpFirst;
    logic [CNT_W-1:0]  cmpSecond;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic              irq;
    logic              armed;
  } tcp_top_s;

  tcp_top_s          r;
  tcp_top_s          n;
  logic              pwmOn;
  logic              firstCapOn;
  logic              wrAck;
  logic              capEvFirst;
  logic              capEvSecond;
  logic [CNT_W-1:0]  capValFirst;
  logic [CNT_W-1:0]  capValSecond;
  logic [STAT_W-1:0] statSet;
  logic [STAT_W-1:0] statClr;
  logic [31:0]       readMux;

  tcp_timebase_if #(.CNT_W(CNT_W)) tb ();

  // ==========================================================
  // Mode decode
  assign pwmOn      = r.ctrl[CTRL_PWM];
  assign firstCapOn = ~(r.ctrl[CTRL_PWM] | r.ctrl[CTRL_SPM]);
  assign wrAck      = (r.bus == TCP_BUS_ACK) && avs_write;

  // ==========================================================
  // Counter and PWM output
  tcp_pwm_unit #(
    .CNT_W (CNT_W)
  ) uPwm (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .pwmOn              (pwmOn),
    .levelFirst         (r.ctrl[CTRL_LVL1]),
    .levelSecond        (r.ctrl[CTRL_LVL2]),
    .compareValueFirst  (r.cmpFirst),
    .compareValueSecond (r.cmpSecond),
    .tb                 (tb.src),
    .compareOutPinFirst (compareOutPinFirst)
  );

  // ==========================================================
  // Capture channels, one per index
  tcp_capture_chan #(
    .CNT_W (CNT_W)
  ) uCapFirst (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .capturePin (capturePinFirst),
    .edgeRising (r.ctrl[CTRL_EDGE1]),
    .enable     (firstCapOn),
    .tb         (tb.snk),
    .capEvent   (capEvFirst),
    .capValue   (capValFirst)
  );

  tcp_capture_chan #(
    .CNT_W (CNT_W)
  ) uCapSecond (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .capturePin (capturePinSecond),
    .edgeRising (r.ctrl[CTRL_EDGE2]),
    .enable     (1'b1),
    .tb         (tb.snk),
    .capEvent   (capEvSecond),
    .capValue   (capValSecond)
  );

  // ==========================================================
  // Status events
  always_comb
  begin
    statSet = '0;
    statSet[STAT_CAP1] = capEvFirst | (pwmOn & tb.matchSecond);
    statSet[STAT_CAP2] = capEvSecond;
    statSet[STAT_CMP1] = ~pwmOn & tb.matchFirst;
    statSet[STAT_CMP2] = ~pwmOn & tb.matchSecond;
    statClr = '0;
    if (wrAck && avs_address == OFS_STATUS && avs_byteenable[0])
    begin
      statClr = avs_writedata[STAT_W-1:0];
    end
  end

  // ==========================================================
  // Read data selection
  always_comb
  begin
    case (avs_address)
      OFS_CTRL:   readMux = 32'(r.ctrl);
      OFS_CMP1:   readMux = 32'(r.cmpFirst);
      OFS_CMP2:   readMux = 32'(r.cmpSecond);
      OFS_CAP1:   readMux = 32'(capValFirst);
      OFS_CAP2:   readMux = 32'(capValSecond);
      OFS_COUNT:  readMux = 32'(tb.count);
      OFS_STATUS: readMux = 32'(r.status);
      OFS_MASK:   readMux = 32'(r.mask);
      default:    readMux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state: bus handshake, register writes, flags
  always_comb
  begin
    n = r;
    n.armed = 1'b1;
    case (r.bus)
      TCP_BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          n.bus     = TCP_BUS_ACK;
          n.waitReq = 1'b0;
          n.rdata   = avs_read ? readMux : 32'h0000_0000;
        end
      end
      TCP_BUS_ACK:
      begin
        n.bus     = TCP_BUS_IDLE;
        n.waitReq = 1'b1;
        if (avs_write)
        begin
          case (avs_address)
            OFS_CTRL:
            begin
              n.ctrl = CTRL_W'(tcp_be_merge(32'(r.ctrl), avs_writedata,
                                            avs_byteenable));
            end
            OFS_CMP1:
            begin
              n.cmpFirst = CNT_W'(tcp_be_merge(32'(r.cmpFirst), avs_writedata,
                                               avs_byteenable));
            end
            OFS_CMP2:
            begin
              n.cmpSecond = CNT_W'(tcp_be_merge(32'(r.cmpSecond), avs_writedata,
                                                avs_byteenable));
            end
            OFS_MASK:
            begin
              n.mask = STAT_W'(tcp_be_merge(32'(r.mask), avs_writedata,
                                            avs_byteenable));
            end
            default:
            begin
              n.mask = r.mask;  // Status clears through statClr; read-only or unmapped: ignored
            end
          endcase
        end
      end
      default:
      begin
        n.bus     = TCP_BUS_IDLE;
        n.waitReq = 1'b1;
      end
    endcase
    // Set wins over a same-cycle write-one clear
    n.status = (r.status & ~statClr) | statSet;
    n.irq    = |(n.status & n.mask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.bus       <= TCP_BUS_IDLE;
      r.waitReq   <= 1'b1;
      r.rdata     <= 32'h0000_0000;
      r.ctrl      <= CTRL_RST;
      r.cmpFirst  <= CNT_W'(CMP1_RST);
      r.cmpSecond <= CNT_W'(CMP2_RST);
      r.status    <= STAT_RST;
      r.mask      <= MASK_RST;
      r.irq       <= 1'b0;
      r.armed     <= 1'b0;
    end
    else
    begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitReq;
  assign irq             = r.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // First channel is silent in PWM or single pulse mode
  AST_CAP1_OFF: assert property (
    !firstCapOn |=> !capEvFirst)
    else $error("first capture fired while reserved");

  // No compare flag is raised while PWM runs
  AST_CMP_QUIET: assert property (
    pwmOn && !r.status[STAT_CMP1] && !r.status[STAT_CMP2]
    |=> !r.status[STAT_CMP1] && !r.status[STAT_CMP2])
    else $error("compare flag set in PWM mode");

  // Match on first value drives the first level
  AST_PWM_LVL1: assert property (
    r.armed && $past(pwmOn) && $stable(r.ctrl) && tb.matchFirst && !tb.matchSecond
    |-> compareOutPinFirst == r.ctrl[CTRL_LVL1])
    else $error("output not at first level after first match");

  // Match on second value drives the second level
  AST_PWM_LVL2: assert property (
    r.armed && $past(pwmOn) && $stable(r.ctrl) && tb.matchSecond
    |-> compareOutPinFirst == r.ctrl[CTRL_LVL2])
    else $error("output not at second level after second match");

  // Period restarts on second match
  AST_PERIOD: assert property (
    r.armed && $past(pwmOn) && tb.matchSecond |-> tb.count == '0)
    else $error("counter did not restart on second match");

  // Counter advances by one otherwise
  AST_FREE_RUN: assert property (
    r.armed && !($past(pwmOn) && tb.matchSecond)
    |-> tb.count == CNT_W'($past(tb.count) + 1'b1))
    else $error("counter stalled or jumped");

  // Capture event raises the channel flag next cycle
  AST_CAP_FLAG: assert property (
    capEvSecond ##0 r.armed |=> r.status[STAT_CAP2])
    else $error("second capture flag not set");

  // Captured value is the counter at the edge
  AST_CAP_VAL: assert property (
    r.armed && capEvSecond |-> capValSecond == $past(tb.count))
    else $error("captured value differs from counter");

  // Second match in PWM sets the first capture flag
  AST_CAP1_PWM: assert property (
    pwmOn && tb.matchSecond |=> r.status[STAT_CAP1])
    else $error("first capture flag missing on second match");

  // Bus answers one cycle after the request is seen
  AST_BUS_ACK: assert property (
    r.bus == TCP_BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle wide");

  // ==========================================================
  // Covers
  COV_PWM_CYCLE: cover property (
    pwmOn && tb.matchFirst ##[1:300] pwmOn && tb.matchSecond);
  COV_CAP_SECOND: cover property (capEvSecond ##1 irq);
  COV_CAP_FIRST: cover property (firstCapOn && capEvFirst);
  COV_W1C_RACE: cover property (|(statSet & statClr));

endmodule : tcp_timer_capture_pwm
